/* File: hw/hssf_pkg.sv */
package hssf_pkg;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_SYSTEM_STATE     = 4'h0;
    localparam logic [3:0] IDX_CONVERTER_STATE  = 4'h1;
    localparam logic [3:0] IDX_PIN_LEVELS       = 4'h2;
    localparam logic [3:0] IDX_LIVE_FAULT_STATE = 4'h3;
    localparam logic [3:0] IDX_LATCHED_FAULTS   = 4'h4;
    localparam logic [3:0] IDX_FAULT_CONFIG     = 4'h5;

    // system_state field positions
    localparam int SYS_GATE_CMD_BIT  = 7;
    localparam int SYS_ENABLE_BIT    = 6;
    localparam int SYS_GATE_PIN_BIT  = 5;
    localparam int SYS_TIMER_LOW_BIT = 3;
    localparam int SYS_NVM_BUSY_BIT  = 2;
    localparam int SYS_PG_BIT        = 1;
    localparam int SYS_ONE_BIT       = 0;

    // converter_state field positions
    localparam int CONV_CH_LSB   = 4;
    localparam int CONV_IDLE_BIT = 3;

    // fault bit positions, shared by live and latched registers
    localparam int FLT_EXT_BIT   = 7;
    localparam int FLT_SHORT_BIT = 6;
    localparam int FLT_VOUT_BIT  = 5;
    localparam int FLT_PGI_BIT   = 4;
    localparam int FLT_BAD_BIT   = 3;
    localparam int FLT_OC_BIT    = 2;
    localparam int FLT_UV_BIT    = 1;
    localparam int FLT_OV_BIT    = 0;

    // fault_config field positions
    localparam int CFG_EXT_EN_BIT  = 0;
    localparam int CFG_EXT_POL_BIT = 1;
    localparam int CFG_PGI_EN_BIT  = 2;
    localparam int CFG_PGI_POL_BIT = 3;

    // reset values
    localparam logic [7:0] LATCHED_FAULTS_RST = 8'h00;
    localparam logic [7:0] FAULT_CONFIG_RST   = 8'h00;
    localparam logic [7:0] LIVE_RST           = 8'h00;

    // reserved channel codes of the converter
    localparam logic [3:0] CONV_CH_RSVD_A = 4'ha;
    localparam logic [3:0] CONV_CH_RSVD_B = 4'hb;

    // analog and monitor conditions presented by the surrounding device
    typedef struct packed {
        logic       gate_commanded_on;
        logic       enable_pin_n;
        logic       gate_pin_high;
        logic       timer_pin_below_level;
        logic       nvm_write_busy;
        logic       power_good_now;
        logic [3:0] aux_conv_channel;
        logic       aux_conv_done;
        logic       conv_snapshot_mode;
        logic       conv_busy;
        logic [3:0] power_good_io_pin;
        logic [3:0] analog_digital_io_pin;
        logic       mosfet_short_now;
        logic       output_below_threshold;
        logic       pg_check_expired;
        logic       mosfet_bad_now;
        logic       current_limit_active;
        logic       undervolt_high_input;
        logic       undervolt_low_input;
        logic       overvoltage_input;
    } hssf_cond_t;

    // fault events raised by the protection logic
    typedef struct packed {
        logic mosfet_short;
        logic mosfet_bad;
        logic overcurrent;
        logic undervoltage;
        logic overvoltage;
        logic pg_input_fault;
    } hssf_evt_t;

endpackage

/* File: hw/hssf_ahb_slave.sv */
`timescale 1ns/10ps
// ahb-lite front end: captures the address phase, issues one-cycle strobes
module hssf_ahb_slave (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    // register side
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [3:0]       reg_idx,
    output logic             reg_hit,
    output logic [7:0]       wr_data
);

    logic       ph_wr_q;
    logic       ph_rd_q;
    logic [3:0] ph_idx_q;
    logic       ph_hit_q;
    logic       take;

    // a transfer is accepted only on nonseq/seq with the bus ready
    assign take = hsel && hready && htrans[1];

    // address phase capture; unmapped words decode as misses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ph_wr_q  <= 1'b0;
            ph_rd_q  <= 1'b0;
            ph_idx_q <= 4'h0;
            ph_hit_q <= 1'b0;
        end else begin
            ph_wr_q  <= take && hwrite;
            ph_rd_q  <= take && !hwrite;
            ph_idx_q <= haddr[5:2];
            ph_hit_q <= (haddr[31:6] == 26'h0) && (haddr[5:2] <= hssf_pkg::IDX_FAULT_CONFIG);
        end
    end

    // data phase: write data valid now, strobes last one cycle
    assign wr_stb  = ph_wr_q;
    assign rd_stb  = ph_rd_q;
    assign reg_idx = ph_idx_q;
    assign reg_hit = ph_hit_q;
    assign wr_data = hwdata[7:0];

    // hsize is always a word here; unused bits are ignored
    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:8]};

endmodule

/* File: hw/hssf_fault_latch.sv */
`timescale 1ns/10ps
// sticky fault register: hardware sets, software clears by writing 0
module hssf_fault_latch (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // events and software write
    input  wire logic [7:0] set_vec,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // state
    output logic [7:0]      faults_q
);

    logic [7:0] faults_d;

    // set wins over clear so an event in the clear cycle survives
    always_comb begin
        faults_d = faults_q;
        if (wr_en) begin
            faults_d = faults_q & wr_data;
        end
        faults_d = faults_d | set_vec;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faults_q <= hssf_pkg::LATCHED_FAULTS_RST;
        end else begin
            faults_q <= faults_d;
        end
    end

endmodule

/* File: hw/hssf_regs.sv */
`timescale 1ns/10ps
// Function
// - status bit7: gate commanded on
// - status bit6: enable pin level
// - status bit5: actual gate pin level
// - status bit3: timer pin below level
// - status bit2: nonvolatile write in progress
// - status bit1: power good met now
// - converter bits7:4: last converted channel code
// - converter bit3: idle in snapshot mode
// - pin levels: power-good io high, analog io low
// - live bit7: external fault level, configured polarity
// - live bit6: mosfet short detected
// - live bit5: output below threshold
// - live bit4: pg input sampled at timer expiry
// - live bit3: bad mosfet present
// - live bit2: current limit engaged
// - live bit1: both undervoltage inputs low
// - live bit0: overvoltage input high
// - latched bit7 external fault; reset clears all
// - latched bit5: output dropped after power good
// - latched short, pg input, bad mosfet bits
// - latched overcurrent, undervoltage, overvoltage bits
module hssf_regs (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // device conditions
    input  wire hssf_pkg::hssf_cond_t cond,
    input  wire hssf_pkg::hssf_evt_t  evt
);

    // strobes and decode from the bus front end
    logic        wr_stb;
    logic        rd_stb;
    logic [3:0]  reg_idx;
    logic        reg_hit;
    logic [7:0]  wr_data;
    logic        rd_take;

    // status snapshots, one per register
    logic [7:0]  system_state_q;
    logic [7:0]  converter_state_q;
    logic [7:0]  pin_levels_q;
    logic [7:0]  live_fault_state_q;

    // software owned configuration
    logic [7:0]  fault_config_q;

    // converter and power good history
    logic [3:0]  last_channel_q;
    logic        pgi_sample_q;
    logic        pg_latched_q;

    // decoded fault levels
    logic        ext_level;
    logic        pgi_level;
    logic        uv_level;

    // sticky fault path
    logic [7:0]  set_vec;
    logic [7:0]  latched_faults_q;

    // read path
    logic [31:0] rdata_d;

    // polarity select for the pg input pin; the external fault pin decodes its own
    function automatic logic pol_level(input logic pin, input logic active_high);
        pol_level = active_high ? pin : !pin;
    endfunction

    // write decode shared by both software-owned registers
    function automatic logic wr_hit(input logic [3:0] idx);
        wr_hit = wr_stb && reg_hit && (reg_idx == idx);
    endfunction

    hssf_ahb_slave u_bus (
        .ref_clk (ref_clk),
        .rst     (rst),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hsize   (hsize),
        .hwdata  (hwdata),
        .hready  (hready),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb),
        .reg_idx (reg_idx),
        .reg_hit (reg_hit),
        .wr_data (wr_data)
    );

    // a read is decoded at its address phase, so its one wait
    // state falls in the first data-phase cycle, not one late
    assign rd_take = hsel && hready && htrans[1] && !hwrite;

    // pgio4 external fault (low-active unless polarity bit set)
    assign ext_level = cond.power_good_io_pin[3] ?
        fault_config_q[hssf_pkg::CFG_EXT_POL_BIT] :
        !fault_config_q[hssf_pkg::CFG_EXT_POL_BIT];
    assign pgi_level = pol_level(cond.power_good_io_pin[2],
                                 fault_config_q[hssf_pkg::CFG_PGI_POL_BIT]);
    assign uv_level  = !cond.undervolt_high_input && !cond.undervolt_low_input;

    // software configuration of the pg pin fault functions
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_config_q <= hssf_pkg::FAULT_CONFIG_RST;
        end else if (wr_hit(hssf_pkg::IDX_FAULT_CONFIG)) begin
            fault_config_q <= {4'h0, wr_data[3:0]};
        end
    end

    // system status snapshot, refreshed every cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            system_state_q <= hssf_pkg::LIVE_RST;
        end else begin
            system_state_q[hssf_pkg::SYS_GATE_CMD_BIT]  <= cond.gate_commanded_on;
            system_state_q[hssf_pkg::SYS_ENABLE_BIT]    <= cond.enable_pin_n;
            system_state_q[hssf_pkg::SYS_GATE_PIN_BIT]  <= cond.gate_pin_high;
            system_state_q[4]                           <= 1'b0;
            system_state_q[hssf_pkg::SYS_TIMER_LOW_BIT] <= cond.timer_pin_below_level;
            system_state_q[hssf_pkg::SYS_NVM_BUSY_BIT]  <= cond.nvm_write_busy;
            system_state_q[hssf_pkg::SYS_PG_BIT]        <= cond.power_good_now;
            system_state_q[hssf_pkg::SYS_ONE_BIT]       <= 1'b1; // reserved reads one
        end
    end

    // channel is held from the last completed conversion
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_channel_q <= 4'h0;
        end else if (cond.aux_conv_done) begin
            last_channel_q <= cond.aux_conv_channel;
        end
    end

    // converter status; reserved low bits read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            converter_state_q <= hssf_pkg::LIVE_RST;
        end else begin
            converter_state_q[7:hssf_pkg::CONV_CH_LSB] <= last_channel_q;
            converter_state_q[hssf_pkg::CONV_IDLE_BIT] <=
                cond.conv_snapshot_mode && !cond.conv_busy;
            converter_state_q[2:0] <= 3'h0;
        end
    end

    // live pin levels
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_levels_q <= hssf_pkg::LIVE_RST;
        end else begin
            // pgio1 lands in bit7, adio1 in bit3
            pin_levels_q <= {cond.power_good_io_pin[0], cond.power_good_io_pin[1],
                             cond.power_good_io_pin[2], cond.power_good_io_pin[3],
                             cond.analog_digital_io_pin[0], cond.analog_digital_io_pin[1],
                             cond.analog_digital_io_pin[2],
                             cond.analog_digital_io_pin[3]};
        end
    end

    // pg input is sampled only when its check timer expires
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pgi_sample_q <= 1'b0;
        end else if (cond.pg_check_expired && fault_config_q[hssf_pkg::CFG_PGI_EN_BIT]) begin
            pgi_sample_q <= pgi_level;
        end
    end

    // live fault status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            live_fault_state_q <= hssf_pkg::LIVE_RST;
        end else begin
            live_fault_state_q[hssf_pkg::FLT_EXT_BIT]   <=
                fault_config_q[hssf_pkg::CFG_EXT_EN_BIT] && ext_level;
            live_fault_state_q[hssf_pkg::FLT_SHORT_BIT] <= cond.mosfet_short_now;
            live_fault_state_q[hssf_pkg::FLT_VOUT_BIT]  <= cond.output_below_threshold;
            live_fault_state_q[hssf_pkg::FLT_PGI_BIT]   <= pgi_sample_q;
            live_fault_state_q[hssf_pkg::FLT_BAD_BIT]   <= cond.mosfet_bad_now;
            live_fault_state_q[hssf_pkg::FLT_OC_BIT]    <= cond.current_limit_active;
            live_fault_state_q[hssf_pkg::FLT_UV_BIT]    <= uv_level;
            live_fault_state_q[hssf_pkg::FLT_OV_BIT]    <= cond.overvoltage_input;
        end
    end

    // power good latch; cleared when power good drops and output is low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pg_latched_q <= 1'b0;
        end else if (cond.power_good_now) begin
            pg_latched_q <= 1'b1;
        end else if (cond.output_below_threshold) begin
            pg_latched_q <= 1'b0;
        end
    end

    // event vector feeding the sticky register
    always_comb begin
        set_vec = 8'h00;
        set_vec[hssf_pkg::FLT_EXT_BIT]   =
            fault_config_q[hssf_pkg::CFG_EXT_EN_BIT] && ext_level;
        set_vec[hssf_pkg::FLT_SHORT_BIT] = evt.mosfet_short;
        set_vec[hssf_pkg::FLT_VOUT_BIT]  =
            pg_latched_q && cond.output_below_threshold;
        set_vec[hssf_pkg::FLT_PGI_BIT]   = evt.pg_input_fault;
        set_vec[hssf_pkg::FLT_BAD_BIT]   = evt.mosfet_bad;
        set_vec[hssf_pkg::FLT_OC_BIT]    = evt.overcurrent;
        set_vec[hssf_pkg::FLT_UV_BIT]    = evt.undervoltage;
        set_vec[hssf_pkg::FLT_OV_BIT]    = evt.overvoltage;
    end

    hssf_fault_latch u_latch (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .set_vec  (set_vec),
        .wr_en    (wr_hit(hssf_pkg::IDX_LATCHED_FAULTS)),
        .wr_data  (wr_data),
        .faults_q (latched_faults_q)
    );

    // read mux; unmapped words read as zero
    //   0 system_state      gate, enable, timer, write, power good
    //   1 converter_state   last channel and idle flag
    //   2 pin_levels        raw io pin levels
    //   3 live_fault_state  current fault conditions and the last pg input sample
    //   4 latched_faults    sticky events, write zero to clear
    //   5 fault_config      pg pin fault enables and polarities
    //   only bits 7:0 carry data
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_hit) begin
            unique case (reg_idx)
                hssf_pkg::IDX_SYSTEM_STATE:     rdata_d[7:0] = system_state_q;
                hssf_pkg::IDX_CONVERTER_STATE:  rdata_d[7:0] = converter_state_q;
                hssf_pkg::IDX_PIN_LEVELS:       rdata_d[7:0] = pin_levels_q;
                hssf_pkg::IDX_LIVE_FAULT_STATE: rdata_d[7:0] = live_fault_state_q;
                hssf_pkg::IDX_LATCHED_FAULTS:   rdata_d[7:0] = latched_faults_q;
                hssf_pkg::IDX_FAULT_CONFIG:     rdata_d[7:0] = fault_config_q;
                default:                        rdata_d[7:0] = 8'h00;
            endcase
        end
    end

    // one wait state per read, low in the first data-phase cycle
    // a read costs a cycle, but hrdata stays off the mux path
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !rd_take;
        end
    end

    // read data moves only on a read, so an idle bus does not toggle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            hrdata <= rdata_d;
        end
    end

    // response is always okay
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

endmodule

/* File: tb/hssf_regs_asserts.sv */
`timescale 1ns/10ps
// checks register read data against the device conditions it mirrors
module hssf_regs_asserts (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // bus
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // device side
    input wire hssf_pkg::hssf_cond_t cond,
    input wire hssf_pkg::hssf_evt_t  evt
);
    logic                 tk;
    logic                 rd1_q;
    logic                 rd2_q;
    logic                 st_q;
    logic                 stab;
    logic [4:0]           idx_q;
    logic [4:0]           ev_q;
    logic [7:0]           sysv;
    logic [7:0]           livev;
    hssf_pkg::hssf_cond_t cond_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // conditions must be steady over the read, else the mirror may lag
    assign tk    = hsel && hready && htrans[1];
    assign stab  = st_q && (cond == cond_q);
    assign sysv  = {cond.gate_commanded_on, cond.enable_pin_n, cond.gate_pin_high, 1'b0,
                    cond.timer_pin_below_level, cond.nvm_write_busy, cond.power_good_now, 1'b1};
    assign livev = {1'b0, cond.mosfet_short_now, cond.output_below_threshold, 1'b0,
                    cond.mosfet_bad_now, cond.current_limit_active,
                    !cond.undervolt_high_input && !cond.undervolt_low_input,
                    cond.overvoltage_input};

    // read pipeline; reset drops stale reads
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd1_q <= 1'b0;
            rd2_q <= 1'b0;
        end else begin
            rd1_q <= tk && !hwrite;
            rd2_q <= rd1_q;
        end
    end

    // address, events and condition history
    always_ff @(posedge ref_clk) begin
        cond_q <= cond;
        st_q   <= (cond == cond_q);
        if (tk) begin
            idx_q <= {haddr[31:6] != 26'h0, haddr[5:2]};
            ev_q  <= {evt.mosfet_short, evt.mosfet_bad, evt.overcurrent, evt.undervoltage,
                      evt.overvoltage};
        end
    end

    property p_resp_okay;
        hresp == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("error response seen");

    property p_rd_wait;
        tk && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

    property p_wr_nowait;
        tk && hwrite |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");

    property p_sys;
        rd2_q && stab && idx_q == 5'h00 |-> (hrdata & 32'h0000_00ef) == {24'h0, sysv};
    endproperty
    a_sys: assert property (p_sys) else $error("system state mismatch");

    property p_conv;
        rd2_q && stab && idx_q == 5'h01 |->
            hrdata[3:0] == {cond.conv_snapshot_mode && !cond.conv_busy, 3'b000};
    endproperty
    a_conv: assert property (p_conv) else $error("converter idle mismatch");

    property p_pins;
        rd2_q && stab && idx_q == 5'h02 |-> hrdata == {24'h0,
            cond.power_good_io_pin[0], cond.power_good_io_pin[1], cond.power_good_io_pin[2],
            cond.power_good_io_pin[3], cond.analog_digital_io_pin[0],
            cond.analog_digital_io_pin[1], cond.analog_digital_io_pin[2],
            cond.analog_digital_io_pin[3]};
    endproperty
    a_pins: assert property (p_pins) else $error("pin levels mismatch");

    property p_live;
        rd2_q && stab && idx_q == 5'h03 |-> (hrdata[7:0] & 8'h6f) == livev;
    endproperty
    a_live: assert property (p_live) else $error("live fault mismatch");

    property p_latch;
        rd2_q && idx_q == 5'h04 |-> ({hrdata[6], hrdata[3:0]} & ev_q) == ev_q;
    endproperty
    a_latch: assert property (p_latch) else $error("fault event not latched");

    property p_unmapped;
        rd2_q && (idx_q[4] || idx_q[3:0] > 4'h5) |-> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_rst_idle;
        disable iff (1'b0) rst |=> hreadyout && hrdata == 32'h0000_0000;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("bus not idle after reset");

    c_read: cover property (rd2_q && idx_q == 5'h04);
    c_write: cover property (tk && hwrite);
    c_event: cover property (evt.overcurrent);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
    logic                 ref_clk, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0]          haddr, hwdata, hrdata, rd;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [3:0]           ch_exp;
    hssf_pkg::hssf_cond_t cond, c;
    hssf_pkg::hssf_evt_t  evt;
    int                   err_total, compares;
    int                   lbit [6] = '{4, 0, 1, 2, 3, 6};

    hssf_regs u_hssf_regs (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cond(cond), .evt(evt));

    // expected mirrors of the status registers
    function automatic logic [7:0] f_sys(hssf_pkg::hssf_cond_t x);
        return {x.gate_commanded_on, x.enable_pin_n, x.gate_pin_high, 1'b0,
                x.timer_pin_below_level, x.nvm_write_busy, x.power_good_now, 1'b1};
    endfunction
    function automatic logic [7:0] f_pins(hssf_pkg::hssf_cond_t x);
        f_pins = {<<{x.analog_digital_io_pin, x.power_good_io_pin}};
    endfunction
    function automatic logic [7:0] f_live(hssf_pkg::hssf_cond_t x);
        return {1'b0, x.mosfet_short_now, x.output_below_threshold, 1'b0, x.mosfet_bad_now,
                x.current_limit_active, !x.undervolt_high_input && !x.undervolt_low_input,
                x.overvoltage_input};
    endfunction

    task end_sim;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one single transfer; a hung wait counts as a mismatch
    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
        r = hrdata;
        if (n >= 50) err_total++;
    endtask

    // read and compare the masked low byte; upper bits must read zero
    task rd_chk(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
        bus(1'b0, a, 32'h0000_0000, rd);
        `CHK(nm, {24'h0, e & m}, rd & {24'hff_ffff, m})
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // watchdog at 20000 cycles, far beyond the few hundred cycles the tests take
    initial begin
        #100000;
        err_total++;
        end_sim;
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        cond = '0;
        evt = '0;
        err_total = 0;
        compares = 0;
        ch_exp = 4'h0;
        void'($urandom(47));
        ticks(2);
        rst <= 1'b0;
        ticks(1);
        rd_chk(32'h10, 8'h00, 8'hff, "latched reset");
        rd_chk(32'h14, 8'h00, 8'hff, "config reset");
        // random conditions; channel codes walk all values, reserved ones never complete
        for (int i = 0; i < 32; i++) begin
            c = hssf_pkg::hssf_cond_t'(29'($urandom));
            c.pg_check_expired = 1'b0;
            c.aux_conv_channel = i[3:0];
            c.aux_conv_done = !(i[3:0] inside {4'ha, 4'hb});
            if (c.aux_conv_done) ch_exp = i[3:0];
            cond <= c;
            ticks(2);
            rd_chk(32'h00, f_sys(c), 8'hef, "system_state");
            rd_chk(32'h04, {ch_exp, c.conv_snapshot_mode && !c.conv_busy, 3'b000}, 8'hff, "conv");
            rd_chk(32'h08, f_pins(c), 8'hff, "pin_levels");
            rd_chk(32'h0c, f_live(c), 8'h6f, "live_fault");
        end
        // read-only and unmapped places ignore writes
        bus(1'b1, 32'h0000_0000, 32'h0000_0000, rd);
        rd_chk(32'h00, f_sys(c), 8'hef, "system_state written");
        bus(1'b1, 32'h0000_0040, 32'h0000_00ff, rd);
        rd_chk(32'h40, 8'h00, 8'hff, "unmapped");
        rd_chk(32'h18, 8'h00, 8'hff, "unmapped index");
        cond <= '0;
        ticks(2);
        bus(1'b1, 32'h10, 32'h0000_0000, rd);
        // each event latches; a clear during the event loses, ones keep, zero clears
        for (int j = 0; j < 6; j++) begin
            evt <= hssf_pkg::hssf_evt_t'(6'(1 << j));
            ticks(1);
            bus(1'b1, 32'h10, 32'h0000_0000, rd);
            evt <= '0;
            ticks(1);
            rd_chk(32'h10, 8'(1 << lbit[j]), 8'hff, "latched set");
            bus(1'b1, 32'h10, 32'h0000_00ff, rd);
            rd_chk(32'h10, 8'(1 << lbit[j]), 8'hff, "latched kept");
            bus(1'b1, 32'h10, 32'h0000_0000, rd);
            rd_chk(32'h10, 8'h00, 8'hff, "latched cleared");
        end
        c = '0;
        c.power_good_now = 1'b1;
        cond <= c;
        ticks(3);
        c.power_good_now = 1'b0;
        c.output_below_threshold = 1'b1;
        cond <= c;
        ticks(3);
        rd_chk(32'h10, 8'h20, 8'h20, "output dropped");
        // external fault on the fourth pin, active low then active high
        cond <= '0;
        bus(1'b1, 32'h14, 32'h0000_0001, rd);
        ticks(2);
        rd_chk(32'h0c, 8'h80, 8'h80, "ext low active");
        rd_chk(32'h10, 8'h80, 8'h80, "ext latched");
        c = '0;
        c.power_good_io_pin = 4'h8;
        cond <= c;
        ticks(2);
        rd_chk(32'h0c, 8'h00, 8'h80, "ext low idle");
        bus(1'b1, 32'h14, 32'h0000_0003, rd);
        ticks(2);
        rd_chk(32'h0c, 8'h80, 8'h80, "ext high active");
        // pg input captured while its check timer expires, then held
        c = '0;
        c.power_good_io_pin = 4'h4;
        c.pg_check_expired = 1'b1;
        cond <= c;
        bus(1'b1, 32'h14, 32'h0000_000c, rd);
        ticks(2);
        rd_chk(32'h0c, 8'h10, 8'h10, "pg input captured");
        cond <= '0;
        ticks(2);
        rd_chk(32'h0c, 8'h10, 8'h10, "pg input held");
        // reset in mid-run clears the sticky faults
        rst <= 1'b1;
        ticks(2);
        rst <= 1'b0;
        ticks(1);
        rd_chk(32'h10, 8'h00, 8'hff, "latched after reset");
        rd_chk(32'h0c, 8'h00, 8'h10, "pg input after reset");
        end_sim;
    end
endmodule

bind hssf_regs hssf_regs_asserts u_hssf_regs_asserts (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cond(cond), .evt(evt));
